// *** pkg/opg_pkg.sv ***
package opg_pkg;
    // Clock and timing
    localparam int unsigned CLK_NS          = 40;
    localparam int unsigned PW_MIN_NS       = 95000;
    localparam int unsigned PW_MAX_NS       = 105000;
    localparam int unsigned PW_TARGET_NS    = 100000;
    localparam int unsigned SETUP_NS        = 2000;
    localparam int unsigned OE_VALID_NS     = 100;
    localparam int unsigned FLOAT_NS        = 130000;
    // Cycle counts and counter width: least times round up, longest times round down
    localparam int unsigned PW_MIN_CYC      = (PW_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned PW_MAX_CYC      = PW_MAX_NS / CLK_NS;
    localparam int unsigned PW_CYC          = PW_TARGET_NS / CLK_NS;
    localparam int unsigned SETUP_CYC       = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned OE_VALID_CYC    = (OE_VALID_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned FLOAT_CYC       = (FLOAT_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned CNT_W           = 13;
    // Pin and data widths, id bit positions, erased byte, retry limit and device count
    localparam int unsigned ADDR_W          = 15;
    localparam int unsigned DATA_W          = 8;
    localparam int unsigned ID_MODE_BIT     = 9;
    localparam int unsigned ID_SEL_BIT      = 0;
    localparam logic [7:0]  ERASED_BYTE     = 8'hFF;
    localparam logic [3:0]  MAX_TRIES       = 4'hA;
    localparam int unsigned NDEV            = 4;

    typedef enum logic [3:0] {
        OPG_IDLE    = 4'b0000,
        OPG_SETUP   = 4'b0001,
        OPG_PULSE   = 4'b0010,
        OPG_HOLD    = 4'b0011,
        OPG_VFY_OE  = 4'b0100,
        OPG_VFY_CMP = 4'b0101,
        OPG_FLOAT   = 4'b0110,
        OPG_SIG_SET = 4'b0111,
        OPG_SIG_RD  = 4'b1000,
        OPG_DONE    = 4'b1001
    } opg_state_t;
endpackage

// *** rtl/opg_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
// Down counter used for all pin timing; done is a registered one-cycle pulse
module opg_timer (
    input  wire logic                     clk_sys,
    input  wire logic                     rst,
    input  wire logic                     load,
    input  wire logic [opg_pkg::CNT_W-1:0] value,
    output logic                          done
);
    logic [opg_pkg::CNT_W-1:0] cnt_reg;
    logic [opg_pkg::CNT_W-1:0] cnt_next;
    logic                      done_reg;
    logic                      done_next;

    always_comb begin
        cnt_next  = cnt_reg;
        done_next = 1'b0;
        if (load) begin
            cnt_next = value;
        end else if (cnt_reg != '0) begin
            cnt_next  = cnt_reg - 1'b1;
            done_next = (cnt_reg == {{(opg_pkg::CNT_W-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_reg  <= '0;
            done_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            done_reg <= done_next;
        end
    end

    assign done = done_reg;
endmodule
`default_nettype wire

// *** rtl/opg_programmer.sv ***
`timescale 1ns/10ps
`default_nettype none
module opg_programmer (
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    input  wire logic                          cmd_prog,
    input  wire logic                          cmd_sig,
    input  wire logic [opg_pkg::NDEV-1:0]      cmd_dev_mask,
    input  wire logic [opg_pkg::ADDR_W-1:0]    cmd_addr,
    input  wire logic [opg_pkg::DATA_W-1:0]    cmd_data,
    output logic                               busy,
    output logic                               done,
    output logic                               fail,
    output logic [opg_pkg::DATA_W-1:0]         sig_mfr,
    output logic [opg_pkg::DATA_W-1:0]         sig_dev,
    output logic [opg_pkg::ADDR_W-1:0]         addr_out,
    output logic                               id_mode_hv,
    output logic                               program_supply_hv,
    output logic [opg_pkg::NDEV-1:0]           sel_n,
    output logic                               oe_n,
    output logic [opg_pkg::DATA_W-1:0]         data_out,
    output logic                               data_oe,
    input  wire logic [opg_pkg::DATA_W-1:0]    data_outputs
);
    ////////////////////////////////////////////////////////////////////////////
    opg_pkg::opg_state_t             st_reg, st_next;
    logic [opg_pkg::NDEV-1:0]        pend_reg, pend_next;
    logic [opg_pkg::NDEV-1:0]        cur_reg, cur_next;
    logic [3:0]                      try_reg, try_next;
    logic                            hi_reg, hi_next;
    logic                            busy_reg, busy_next;
    logic                            done_reg, done_next;
    logic                            fail_reg, fail_next;
    logic [opg_pkg::DATA_W-1:0]      mfr_reg, mfr_next;
    logic [opg_pkg::DATA_W-1:0]      dev_reg, dev_next;
    logic [opg_pkg::ADDR_W-1:0]      addr_reg, addr_next;
    logic                            idhv_reg, idhv_next;
    logic                            vpp_reg, vpp_next;
    logic [opg_pkg::NDEV-1:0]        seln_reg, seln_next;
    logic                            oen_reg, oen_next;
    logic [opg_pkg::DATA_W-1:0]      dout_reg, dout_next;
    logic                            doe_reg, doe_next;
    logic                            tload;
    logic [opg_pkg::CNT_W-1:0]       tval;
    logic                            tdone;
    logic [opg_pkg::NDEV-1:0]        first_dev;

    opg_timer u_timer (
        .clk_sys (clk_sys),
        .rst     (rst),
        .load    (tload),
        .value   (tval),
        .done    (tdone)
    );

    // Lowest pending device; one select line per device
    always_comb begin
        first_dev = '0;
        for (int i = opg_pkg::NDEV - 1; i >= 0; i--) begin
            if (pend_reg[i]) begin
                first_dev = '0;
                first_dev[i] = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_next   = st_reg;
        pend_next = pend_reg;
        cur_next  = cur_reg;
        try_next  = try_reg;
        hi_next   = hi_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        fail_next = fail_reg;
        mfr_next  = mfr_reg;
        dev_next  = dev_reg;
        addr_next = addr_reg;
        idhv_next = idhv_reg;
        vpp_next  = vpp_reg;
        seln_next = seln_reg;
        oen_next  = oen_reg;
        dout_next = dout_reg;
        doe_next  = doe_reg;
        tload     = 1'b0;
        tval      = '0;
        case (st_reg)
            opg_pkg::OPG_IDLE: begin
                seln_next = '1;
                oen_next  = 1'b1;
                if (cmd_prog && cmd_dev_mask != '0) begin
                    busy_next = 1'b1;
                    fail_next = 1'b0;
                    pend_next = cmd_dev_mask;
                    addr_next = cmd_addr;
                    dout_next = cmd_data;
                    doe_next  = 1'b1;
                    vpp_next  = 1'b1;
                    try_next  = '0;
                    tload     = 1'b1;
                    tval      = opg_pkg::CNT_W'(opg_pkg::SETUP_CYC);
                    st_next   = opg_pkg::OPG_SETUP;
                end else if (cmd_sig) begin
                    busy_next = 1'b1;
                    fail_next = 1'b0;
                    // All but the id, select and output-enable lines low
                    addr_next = '0;
                    idhv_next = 1'b1;
                    vpp_next  = 1'b0;
                    doe_next  = 1'b0;
                    hi_next   = 1'b0;
                    tload     = 1'b1;
                    tval      = opg_pkg::CNT_W'(opg_pkg::SETUP_CYC);
                    st_next   = opg_pkg::OPG_SIG_SET;
                end
            end
            opg_pkg::OPG_SETUP: begin
                if (tdone) begin
                    cur_next  = first_dev;
                    seln_next = ~first_dev;
                    tload     = 1'b1;
                    tval      = opg_pkg::CNT_W'(opg_pkg::PW_CYC);
                    st_next   = opg_pkg::OPG_PULSE;
                end
            end
            opg_pkg::OPG_PULSE: begin
                if (tdone) begin
                    seln_next = '1;
                    try_next  = try_reg + 4'h1;
                    tload     = 1'b1;
                    tval      = opg_pkg::CNT_W'(opg_pkg::SETUP_CYC);
                    st_next   = opg_pkg::OPG_HOLD;
                end
            end
            opg_pkg::OPG_HOLD: begin
                if (tdone) begin
                    // Release data bus so the device can drive it
                    doe_next = 1'b0;
                    tload    = 1'b1;
                    tval     = opg_pkg::CNT_W'(opg_pkg::SETUP_CYC);
                    st_next  = opg_pkg::OPG_VFY_OE;
                end
            end
            opg_pkg::OPG_VFY_OE: begin
                if (tdone) begin
                    oen_next = 1'b0;
                    tload    = 1'b1;
                    tval     = opg_pkg::CNT_W'(opg_pkg::OE_VALID_CYC + 1);
                    st_next  = opg_pkg::OPG_VFY_CMP;
                end
            end
            opg_pkg::OPG_VFY_CMP: begin
                if (tdone) begin
                    oen_next = 1'b1;
                    tload    = 1'b1;
                    tval     = opg_pkg::CNT_W'(opg_pkg::FLOAT_CYC);
                    st_next  = opg_pkg::OPG_FLOAT;
                    // Device margins itself: a match ends the byte
                    if (data_outputs == dout_reg) begin
                        pend_next = pend_reg & ~cur_reg;
                        try_next  = '0;
                    end else if (try_reg >= opg_pkg::MAX_TRIES) begin
                        fail_next = 1'b1;
                        pend_next = '0;
                    end
                end
            end
            opg_pkg::OPG_FLOAT: begin
                if (tdone) begin
                    if (pend_reg == '0) begin
                        vpp_next = 1'b0;
                        st_next  = opg_pkg::OPG_DONE;
                    end else begin
                        doe_next = 1'b1;
                        tload    = 1'b1;
                        tval     = opg_pkg::CNT_W'(opg_pkg::SETUP_CYC);
                        st_next  = opg_pkg::OPG_SETUP;
                    end
                end
            end
            opg_pkg::OPG_SIG_SET: begin
                if (tdone) begin
                    seln_next = '0;
                    oen_next  = 1'b0;
                    tload     = 1'b1;
                    tval      = opg_pkg::CNT_W'(opg_pkg::SETUP_CYC);
                    st_next   = opg_pkg::OPG_SIG_RD;
                end
            end
            opg_pkg::OPG_SIG_RD: begin
                if (tdone) begin
                    if (!hi_reg) begin
                        mfr_next = data_outputs;
                        // Flip only the select line, no latch strobe
                        hi_next = 1'b1;
                        addr_next[opg_pkg::ID_SEL_BIT] = 1'b1;
                        tload = 1'b1;
                        tval  = opg_pkg::CNT_W'(opg_pkg::SETUP_CYC);
                    end else begin
                        dev_next  = data_outputs;
                        seln_next = '1;
                        oen_next  = 1'b1;
                        idhv_next = 1'b0;
                        addr_next = '0;
                        st_next   = opg_pkg::OPG_DONE;
                    end
                end
            end
            opg_pkg::OPG_DONE: begin
                busy_next = 1'b0;
                done_next = 1'b1;
                st_next   = opg_pkg::OPG_IDLE;
            end
            default: begin
                st_next = opg_pkg::OPG_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_reg   <= opg_pkg::OPG_IDLE;
            pend_reg <= '0;
            cur_reg  <= '0;
            try_reg  <= '0;
            hi_reg   <= 1'b0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            fail_reg <= 1'b0;
            mfr_reg  <= '0;
            dev_reg  <= '0;
            addr_reg <= '0;
            idhv_reg <= 1'b0;
            vpp_reg  <= 1'b0;
            seln_reg <= '1;
            oen_reg  <= 1'b1;
            dout_reg <= opg_pkg::ERASED_BYTE;
            doe_reg  <= 1'b0;
        end else begin
            st_reg   <= st_next;
            pend_reg <= pend_next;
            cur_reg  <= cur_next;
            try_reg  <= try_next;
            hi_reg   <= hi_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            fail_reg <= fail_next;
            mfr_reg  <= mfr_next;
            dev_reg  <= dev_next;
            addr_reg <= addr_next;
            idhv_reg <= idhv_next;
            vpp_reg  <= vpp_next;
            seln_reg <= seln_next;
            oen_reg  <= oen_next;
            dout_reg <= dout_next;
            doe_reg  <= doe_next;
        end
    end

    assign busy              = busy_reg;
    assign done              = done_reg;
    assign fail              = fail_reg;
    assign sig_mfr           = mfr_reg;
    assign sig_dev           = dev_reg;
    assign addr_out          = addr_reg;
    assign id_mode_hv        = idhv_reg;
    assign program_supply_hv = vpp_reg;
    assign sel_n             = seln_reg;
    assign oe_n              = oen_reg;
    assign data_out          = dout_reg;
    assign data_oe           = doe_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Pulse width counter seen only by the checks
    logic [opg_pkg::CNT_W-1:0] pw_cnt;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pw_cnt <= '0;
        end else if (&seln_reg) begin
            pw_cnt <= '0;
        end else begin
            pw_cnt <= pw_cnt + 1'b1;
        end
    end

    property p_pw_max;
        @(posedge clk_sys) disable iff (rst)
        (vpp_reg && !(&seln_reg)) |-> pw_cnt < opg_pkg::CNT_W'(opg_pkg::PW_MAX_CYC);
    endproperty
    a_pw_max: assert property (p_pw_max) else $error("program pulse too long");

    property p_pw_min;
        @(posedge clk_sys) disable iff (rst)
        (vpp_reg && !(&seln_reg) && (&seln_next)) |-> pw_cnt + 1'b1 >= opg_pkg::CNT_W'(opg_pkg::PW_MIN_CYC);
    endproperty
    a_pw_min: assert property (p_pw_min) else $error("program pulse too short");

    property p_one_sel;
        @(posedge clk_sys) disable iff (rst)
        vpp_reg |-> $countones(~seln_reg) <= 1;
    endproperty
    a_one_sel: assert property (p_one_sel) else $error("two devices selected while programming");

    property p_sig_pins;
        @(posedge clk_sys) disable iff (rst)
        idhv_reg |-> !vpp_reg && (addr_reg >> 1) == '0;
    endproperty
    a_sig_pins: assert property (p_sig_pins) else $error("signature mode pins wrong");

    property p_vfy_float;
        @(posedge clk_sys) disable iff (rst)
        $fell(oen_reg) |-> !doe_reg;
    endproperty
    a_vfy_float: assert property (p_vfy_float) else $error("bus contention on verify");

    property p_retry;
        @(posedge clk_sys) disable iff (rst)
        $rose(fail_reg) |-> try_reg >= opg_pkg::MAX_TRIES;
    endproperty
    a_retry: assert property (p_retry) else $error("failed before retry limit");
endmodule
`default_nettype wire

// *** tb/opg_dev_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Behavioural model of four memory devices sharing every pin except select
module opg_dev_model #(
    parameter logic [7:0] MFR_ID = 8'h5A,  // Arbitrary value
    parameter logic [7:0] DEV_ID = 8'hC3   // Arbitrary value
) (
    input  wire logic                       clk_sys,
    input  wire logic [opg_pkg::ADDR_W-1:0] addr_out,
    input  wire logic                       id_mode_hv,
    input  wire logic                       program_supply_hv,
    input  wire logic [opg_pkg::NDEV-1:0]   sel_n,
    input  wire logic                       oe_n,
    input  wire logic [opg_pkg::DATA_W-1:0] data_out,
    input  wire logic                       data_oe,
    input  wire logic [opg_pkg::NDEV-1:0]   slow_mask,
    output logic      [opg_pkg::DATA_W-1:0] data_outputs
);
    logic [7:0]               mem [int];
    int                       pulse_cnt [opg_pkg::NDEV];
    int                       sig_addr_err;
    int                       last_dev;
    logic [opg_pkg::NDEV-1:0] sel_q;
    logic [opg_pkg::NDEV-1:0] half;
    logic [7:0]               last_q;
    logic [7:0]               dval;
    logic                     drv;

    function automatic logic [7:0] rd(input int dev, input logic [14:0] a);
        int k;
        k = dev * 32768 + int'(a);
        rd = mem.exists(k) ? mem[k] : opg_pkg::ERASED_BYTE;
    endfunction

    initial begin
        foreach (pulse_cnt[i]) pulse_cnt[i] = 0;
        sig_addr_err = 0;
        last_dev = 0;
        sel_q = 4'hF;
        half = 4'h0;
        last_q = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin
        for (int i = 0; i < opg_pkg::NDEV; i++) begin
            // Cells take the byte as select rises; a device whose select stays high is left alone
            if (program_supply_hv && !id_mode_hv && oe_n && data_oe && !sel_q[i] && sel_n[i]) begin
                pulse_cnt[i] = pulse_cnt[i] + 1;
                last_dev = i;
                half[i] = ~half[i];
                // A slow device needs two pulses, which forces the retry path
                if (!slow_mask[i] || !half[i]) begin
                    mem[i * 32768 + int'(addr_out)] = rd(i, addr_out) & data_out;
                end
            end
        end
        if (id_mode_hv && !program_supply_hv && (addr_out & 15'h7FFE) != 15'h0000) begin
            sig_addr_err = sig_addr_err + 1;
        end
        sel_q <= sel_n;
        last_q <= data_outputs;
    end

    always_comb begin
        drv = 1'b0;
        dval = 8'h00;
        for (int i = 0; i < opg_pkg::NDEV; i++) begin
            if (id_mode_hv && !program_supply_hv && !sel_n[i] && !oe_n) begin
                drv = 1'b1;
                dval = addr_out[opg_pkg::ID_SEL_BIT] ? DEV_ID : MFR_ID;
            end else if (program_supply_hv && sel_n[i] && !oe_n && last_dev == i) begin
                // Margin is applied inside the cell, so one good read ends the byte
                drv = 1'b1;
                dval = rd(i, addr_out);
            end else if (!id_mode_hv && !program_supply_hv && !sel_n[i] && !oe_n) begin
                drv = 1'b1;
                dval = rd(i, addr_out);
            end
        end
    end

    // No pull-up on the data lines: an undriven bus shows a changing pattern
    assign data_outputs = data_oe ? data_out : (drv ? dval : ~last_q);
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam logic [7:0] MFR_ID = 8'h5A;  // Arbitrary value
    localparam logic [7:0] DEV_ID = 8'hC3;  // Arbitrary value
    logic                       clk_sys;
    logic                       rst;
    logic                       cmd_prog;
    logic                       cmd_sig;
    logic [opg_pkg::NDEV-1:0]   cmd_dev_mask;
    logic [opg_pkg::ADDR_W-1:0] cmd_addr;
    logic [opg_pkg::DATA_W-1:0] cmd_data;
    logic                       busy;
    logic                       done;
    logic                       fail;
    logic [opg_pkg::DATA_W-1:0] sig_mfr;
    logic [opg_pkg::DATA_W-1:0] sig_dev;
    logic [opg_pkg::ADDR_W-1:0] addr_out;
    logic                       id_mode_hv;
    logic                       program_supply_hv;
    logic [opg_pkg::NDEV-1:0]   sel_n;
    logic                       oe_n;
    logic [opg_pkg::DATA_W-1:0] data_out;
    logic                       data_oe;
    logic [opg_pkg::DATA_W-1:0] data_outputs;
    logic [opg_pkg::NDEV-1:0]   slow_mask;
    int                         miscompares;
    int                         tests_run;
    int                         pw;
    int                         base [opg_pkg::NDEV];

    opg_programmer dut (.clk_sys(clk_sys), .rst(rst), .cmd_prog(cmd_prog), .cmd_sig(cmd_sig),
        .cmd_dev_mask(cmd_dev_mask), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .busy(busy), .done(done),
        .fail(fail), .sig_mfr(sig_mfr), .sig_dev(sig_dev), .addr_out(addr_out), .id_mode_hv(id_mode_hv),
        .program_supply_hv(program_supply_hv), .sel_n(sel_n), .oe_n(oe_n), .data_out(data_out),
        .data_oe(data_oe), .data_outputs(data_outputs));

    opg_dev_model #(.MFR_ID(MFR_ID), .DEV_ID(DEV_ID)) pm (.clk_sys(clk_sys), .addr_out(addr_out),
        .id_mode_hv(id_mode_hv), .program_supply_hv(program_supply_hv), .sel_n(sel_n), .oe_n(oe_n),
        .data_out(data_out), .data_oe(data_oe), .slow_mask(slow_mask), .data_outputs(data_outputs));

    always #20 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%0h expected=%0h", $time, seen, exp);
        end
    endtask

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Issue one command and wait for its done pulse under a bound
    task automatic run_cmd(input logic prog, input logic [3:0] mask, input logic [14:0] a, input logic [7:0] d);
        int n;
        n = 0;
        foreach (base[i]) base[i] = pm.pulse_cnt[i];
        @(posedge clk_sys);
        cmd_prog <= prog;
        cmd_sig <= !prog;
        cmd_dev_mask <= mask;
        cmd_addr <= a;
        cmd_data <= d;
        @(posedge clk_sys);
        cmd_prog <= 1'b0;
        cmd_sig <= 1'b0;
        @(posedge clk_sys);
        n++;
        chk(32'(busy), 32'h1);
        while (done !== 1'b1 && n < 70000) begin
            @(posedge clk_sys);
            n++;
        end
        chk(32'(n < 70000), 32'h1);
        #1;
        // Select, output-enable and data-enable pins back to idle and busy low once the command has ended
        chk(32'({busy, sel_n, oe_n, data_oe}), 32'h3E);
    endtask

    // Every select pulse taken at programming supply is timed here
    always @(posedge clk_sys) begin
        if (program_supply_hv === 1'b1 && sel_n !== 4'hF) begin
            pw <= pw + 1;
        end else if (pw != 0) begin
            chk(32'(pw >= int'(opg_pkg::PW_MIN_CYC) && pw <= int'(opg_pkg::PW_MAX_CYC)), 32'h1);
            pw <= 0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_refuse;
        @(posedge clk_sys);
        cmd_prog <= 1'b1;
        cmd_dev_mask <= 4'h0;
        @(posedge clk_sys);
        cmd_prog <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk(32'({busy, sel_n, program_supply_hv}), 32'h1E);
        $display("test refuse done");
    endtask

    task automatic t_sig;
        run_cmd(1'b0, 4'h0, 15'h0000, 8'h00);
        chk(32'(sig_mfr), 32'(MFR_ID));
        chk(32'(sig_dev), 32'(DEV_ID));
        chk(32'(pm.sig_addr_err), 32'h0);
        chk(32'({fail, id_mode_hv}), 32'h0);
        $display("test signature done");
    endtask

    task automatic t_prog_one;
        run_cmd(1'b1, 4'b0001, 15'h0123, 8'hA5);
        chk(32'(pm.rd(0, 15'h0123)), 32'hA5);
        chk(32'({pm.rd(1, 15'h0123), pm.rd(2, 15'h0123), pm.rd(3, 15'h0123)}), 32'hFFFFFF);
        chk(32'(pm.pulse_cnt[0] - base[0]), 32'h1);
        chk(32'(fail), 32'h0);
        $display("test program single done");
    endtask

    task automatic t_prog_retry;
        slow_mask <= 4'b1000;
        run_cmd(1'b1, 4'b1010, 15'h4321, 8'h3C);
        chk(32'({pm.rd(1, 15'h4321), pm.rd(3, 15'h4321)}), 32'h3C3C);
        chk(32'({pm.rd(0, 15'h4321), pm.rd(2, 15'h4321)}), 32'hFFFF);
        chk(32'(pm.pulse_cnt[1] - base[1]), 32'h1);
        chk(32'(pm.pulse_cnt[3] - base[3]), 32'h2);
        chk(32'(fail), 32'h0);
        $display("test program retry done");
    endtask

    task automatic t_prog_fail;
        // Raising bits is impossible, so this byte never verifies
        run_cmd(1'b1, 4'b0001, 15'h0123, 8'h5A);
        chk(32'(pm.rd(0, 15'h0123)), 32'h00);
        chk(32'(pm.pulse_cnt[0] - base[0]), 32'(opg_pkg::MAX_TRIES));
        chk(32'({fail, program_supply_hv}), 32'h2);
        $display("test program failure done");
    endtask

    initial begin
        clk_sys = 1'b0;
        rst = 1'b1;
        cmd_prog = 1'b0;
        cmd_sig = 1'b0;
        cmd_dev_mask = 4'h0;
        cmd_addr = 15'h0000;
        cmd_data = 8'h00;
        slow_mask = 4'h0;
        miscompares = 0;
        tests_run = 0;
        pw = 0;
        repeat (10) @(posedge clk_sys);
        chk(32'({sel_n, oe_n, data_oe, program_supply_hv, id_mode_hv, busy, done, fail, data_out}), 32'h7C0FF);
        rst <= 1'b0;
        $display("test reset done");
        t_refuse();
        t_sig();
        t_prog_one();
        t_prog_retry();
        t_prog_fail();
        results();
    end

    initial begin
        repeat (120000) @(posedge clk_sys);
        miscompares++;
        $display("[ERR] t=%0t seen=%0h expected=%0h", $time, 0, 1);
        results();
    end
endmodule
`default_nettype wire
